// [hw/card_cmd_pkg.sv]
// constants, field positions and enumerations of the card command decoder
// assumes a single 100 MHz clock domain and a classic wishbone register bus
package card_cmd_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_HDR = 8'h04;
	localparam logic [7:0] OFF_OPT = 8'h08;
	localparam logic [7:0] OFF_DATA0 = 8'h0c;
	localparam logic [7:0] OFF_DATA1 = 8'h10;
	localparam logic [7:0] OFF_DATA2 = 8'h14;
	localparam logic [7:0] OFF_DATA3 = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [7:0] OFF_FILES = 8'h20;
	localparam logic [7:0] OFF_RESP0 = 8'h24;
	localparam logic [7:0] OFF_RESP1 = 8'h28;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_START_BIT = 8;
	localparam int OPT_LE_BIT = 0;
	localparam int OPT_SUSPEND_AC_BIT = 1;
	localparam int OPT_RESUME_AC_BIT = 2;
	localparam int OPT_FILE_LSB = 8;
	localparam int P2_SPECIFIC_BIT = 7;

	// ----------------------------------------------------------------
	// header codings and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] P_ZERO = 8'h00;
	localparam logic [7:0] UNBLOCK_LC = 8'h10;
	localparam logic [7:0] SEL_BY_ID = 8'h00;
	localparam logic [7:0] SEL_BY_NAME = 8'h04;
	localparam logic [7:0] SEL_BY_PATH = 8'h08;
	localparam logic [4:0] KEY_NUM_MIN = 5'h01;
	localparam logic [3:0] UNBLOCK_TRIES_INIT = 4'ha;
	localparam logic [3:0] CODE_TRIES_INIT = 4'h3;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		CMD_UNBLOCK,
		CMD_SUSPEND,
		CMD_RESUME,
		CMD_CHALLENGE,
		CMD_PROFILE,
		CMD_WRAPPED,
		CMD_FILE_OP,
		CMD_SELECT
	} cmd_t;

	typedef enum logic [2:0] {
		RES_NONE,
		RES_OK,
		RES_BAD_PARAM,
		RES_DENIED,
		RES_REFUSED,
		RES_WRONG_CODE,
		RES_BLOCKED
	} res_t;

endpackage : card_cmd_pkg

// [hw/card_command_decoder.sv]
// card-side command decoder: header checks, code unblocking, file
// suspend/resume state and challenge-response computation
// assumes a classic wishbone master on clk_i; por_i is the cold start
//
// How it works
// [RULE1] unblock needs p1 zero, lc 0x10, no le; else rejected
// [RULE2] unblock payload: bytes 1-8 unblocking code, bytes 9-16 new code
// [RULE3] unblock p2 coded as for verify: scope bit plus number 01..1f
// [RULE4] suspend sets the addressed file's suspended flag, data untouched
// [RULE5] suspend only when its access condition holds, else no change
// [RULE6] suspended file refuses every operation except select and resume; the decoder refuses only CMD_FILE_OP, a repeated suspend is not refused
// [RULE7] resume clears the suspended flag of the file
// [RULE8] resume only when its access condition holds, else no change
// [RULE9] suspend/resume p1/p2 as for select, optional data, no le
// [RULE10] terminal selects a suitable application before challenge
// [RULE11] challenge response computed from challenge and card secret
// [RULE12] challenge p1 zero means the application's implied algorithm
// [RULE13] challenge p2 bit 8 picks global or specific key
// [RULE14] challenge p2 bits 7 and 6 must be zero
// [RULE15] challenge p2 bits 5..1 give key number 01..1f
// [RULE16] challenge p2 zero means the application's implied key
// [RULE17] challenge takes lc input bytes and returns le bytes
// [RULE18] capability profile: p1 p2 zero, lc data, no le
// [RULE19] wrapped transfer: p1 p2 zero, lc data, le empty or a limit
// [RULE20] right unblock code installs new code, counters 10 and 3
// [RULE21] wrong unblock code decrements counter, blocks at zero
// [RULE22] bad header field rejects the command, no state changes
// [RULE23] suspended flags kept as non-volatile state across resets; the decoder keeps them across rst_i only, por_i clears them
//
// Local design decisions: the address map and the Wishbone interface to the registers.
module card_command_decoder #(
	parameter int NUM_FILES = 16,
	// arbitrary initial secrets
	parameter logic [63:0] UNBLOCK_CODE_INIT = 64'h3837_3635_3433_3231,
	parameter logic [63:0] CODE_INIT = 64'hffff_ffff_3433_3231,
	parameter logic [63:0] CARD_SECRET = 64'h0123_4567_89ab_cdef
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o
);

	localparam int FW = $clog2(NUM_FILES);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] wmerge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// reference byte: scope bit, two zero bits, number 01..1f
	function automatic logic ref_ok(input logic [7:0] p);
		return (p[6:5] == 2'b00) && (p[4:0] >= card_cmd_pkg::KEY_NUM_MIN);
	endfunction : ref_ok

	function automatic logic sel_p1_ok(input logic [7:0] p);
		return (p == card_cmd_pkg::SEL_BY_ID) ||
			(p == card_cmd_pkg::SEL_BY_NAME) ||
			(p == card_cmd_pkg::SEL_BY_PATH);
	endfunction : sel_p1_ok

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	card_cmd_pkg::cmd_t kind_reg;
	card_cmd_pkg::res_t result_reg, result_next;
	logic [31:0] hdr_reg;
	logic [31:0] opt_reg;
	logic [31:0] data_reg [0:3];
	logic [63:0] resp_reg;
	logic key_spec_reg;
	logic [4:0] key_num_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	// non-volatile state, untouched by rst_i
	logic [NUM_FILES-1:0] files_reg;
	logic [63:0] unblock_code_reg;
	logic [63:0] code_reg;
	logic [3:0] unblock_ctr_reg;
	logic [3:0] code_ctr_reg;
	logic code_en_reg;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire req = cyc_i && stb_i;
	wire wr_en = req && we_i && ack_reg;
	wire hit_ctrl = adr_i == card_cmd_pkg::OFF_CTRL;
	wire hit_hdr = adr_i == card_cmd_pkg::OFF_HDR;
	wire hit_opt = adr_i == card_cmd_pkg::OFF_OPT;
	wire hit_data = (adr_i >= card_cmd_pkg::OFF_DATA0) &&
		(adr_i <= card_cmd_pkg::OFF_DATA3) && (adr_i[1:0] == 2'b00);
	wire [7:0] data_off = adr_i - card_cmd_pkg::OFF_DATA0;
	wire [1:0] data_idx = data_off[3:2];
	wire exec = wr_en && hit_ctrl && sel_i[1] &&
		dat_i[card_cmd_pkg::CTRL_START_BIT];
	wire card_cmd_pkg::cmd_t cmd = card_cmd_pkg::cmd_t'(dat_i[2:0]);

	// ----------------------------------------------------------------
	// header fields
	// ----------------------------------------------------------------
	wire [7:0] p1 = hdr_reg[7:0];
	wire [7:0] p2 = hdr_reg[15:8];
	wire [7:0] lc = hdr_reg[23:16];
	wire le_pres = opt_reg[card_cmd_pkg::OPT_LE_BIT];
	wire ac_suspend = opt_reg[card_cmd_pkg::OPT_SUSPEND_AC_BIT];
	wire ac_resume = opt_reg[card_cmd_pkg::OPT_RESUME_AC_BIT];
	wire [FW-1:0] fidx = opt_reg[card_cmd_pkg::OPT_FILE_LSB +: FW];
	wire file_off = files_reg[fidx];
	wire p1_zero = p1 == card_cmd_pkg::P_ZERO;
	wire p2_zero = p2 == card_cmd_pkg::P_ZERO;
	wire [63:0] old_code = {data_reg[1], data_reg[0]}; // [RULE2]
	wire [63:0] new_code = {data_reg[3], data_reg[2]}; // [RULE2]
	wire unb_blocked = unblock_ctr_reg == 4'h0;
	wire unb_match = old_code == unblock_code_reg;

	logic hdr_ok;
	always_comb begin
		case (cmd)
			card_cmd_pkg::CMD_UNBLOCK: begin
				hdr_ok = p1_zero && (lc == card_cmd_pkg::UNBLOCK_LC) &&
					!le_pres && ref_ok(p2); // [RULE1] [RULE3]
			end
			card_cmd_pkg::CMD_SUSPEND, card_cmd_pkg::CMD_RESUME: begin
				hdr_ok = sel_p1_ok(p1) && !le_pres; // [RULE9]
			end
			card_cmd_pkg::CMD_CHALLENGE: begin
				// [RULE12] [RULE14] [RULE15] [RULE16] [RULE17]
				hdr_ok = p1_zero && (p2_zero || ref_ok(p2)) &&
					(lc != card_cmd_pkg::P_ZERO) && le_pres;
			end
			card_cmd_pkg::CMD_PROFILE: begin
				hdr_ok = p1_zero && p2_zero && !le_pres; // [RULE18]
			end
			card_cmd_pkg::CMD_WRAPPED: begin
				hdr_ok = p1_zero && p2_zero; // [RULE19]
			end
			default: begin
				hdr_ok = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// command outcome
	// ----------------------------------------------------------------
	wire unb_try = exec && (cmd == card_cmd_pkg::CMD_UNBLOCK) && hdr_ok &&
		!unb_blocked;
	wire unb_good = unb_try && unb_match;
	wire unb_bad = unb_try && !unb_match;
	wire do_suspend = exec && (cmd == card_cmd_pkg::CMD_SUSPEND) && hdr_ok &&
		ac_suspend;
	wire do_resume = exec && (cmd == card_cmd_pkg::CMD_RESUME) && hdr_ok &&
		ac_resume;
	wire do_chal = exec && (cmd == card_cmd_pkg::CMD_CHALLENGE) && hdr_ok;

	always_comb begin
		if (!hdr_ok) begin
			result_next = card_cmd_pkg::RES_BAD_PARAM; // [RULE22]
		end else begin
			case (cmd)
				card_cmd_pkg::CMD_UNBLOCK: begin
					result_next = unb_blocked ? card_cmd_pkg::RES_BLOCKED :
						unb_match ? card_cmd_pkg::RES_OK :
						card_cmd_pkg::RES_WRONG_CODE;
				end
				card_cmd_pkg::CMD_SUSPEND: begin
					result_next = ac_suspend ? card_cmd_pkg::RES_OK :
						card_cmd_pkg::RES_DENIED; // [RULE5]
				end
				card_cmd_pkg::CMD_RESUME: begin
					result_next = ac_resume ? card_cmd_pkg::RES_OK :
						card_cmd_pkg::RES_DENIED; // [RULE8]
				end
				card_cmd_pkg::CMD_FILE_OP: begin
					result_next = file_off ? card_cmd_pkg::RES_REFUSED :
						card_cmd_pkg::RES_OK; // [RULE6]
				end
				default: begin
					result_next = card_cmd_pkg::RES_OK;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// bus slave and software registers
	// ----------------------------------------------------------------
	logic [31:0] rmux;
	always_comb begin
		case (adr_i)
			card_cmd_pkg::OFF_CTRL: rmux = {29'h0, kind_reg};
			card_cmd_pkg::OFF_HDR: rmux = hdr_reg;
			card_cmd_pkg::OFF_OPT: rmux = opt_reg;
			card_cmd_pkg::OFF_DATA0, card_cmd_pkg::OFF_DATA1,
			card_cmd_pkg::OFF_DATA2, card_cmd_pkg::OFF_DATA3: begin
				rmux = data_reg[data_idx];
			end
			card_cmd_pkg::OFF_STATUS: rmux = {8'h00, key_spec_reg, 2'b00,
				key_num_reg, 3'b000, code_en_reg, code_ctr_reg,
				unblock_ctr_reg, 1'b0, result_reg};
			card_cmd_pkg::OFF_FILES: rmux = 32'(files_reg);
			card_cmd_pkg::OFF_RESP0: rmux = resp_reg[31:0];
			card_cmd_pkg::OFF_RESP1: rmux = resp_reg[63:32];
			default: rmux = card_cmd_pkg::REG_RESET;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= card_cmd_pkg::REG_RESET;
		end else begin
			ack_reg <= req && !ack_reg;
			if (req && !ack_reg) begin
				rdata_reg <= rmux;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			kind_reg <= card_cmd_pkg::CMD_UNBLOCK;
			hdr_reg <= card_cmd_pkg::REG_RESET;
			opt_reg <= card_cmd_pkg::REG_RESET;
			for (int i = 0; i < 4; i++) begin
				data_reg[i] <= card_cmd_pkg::REG_RESET;
			end
		end else if (wr_en) begin
			if (hit_ctrl && sel_i[0]) begin
				kind_reg <= cmd;
			end
			if (hit_hdr) begin
				hdr_reg <= wmerge(hdr_reg, dat_i, sel_i);
			end
			if (hit_opt) begin
				opt_reg <= wmerge(opt_reg, dat_i, sel_i);
			end
			if (hit_data) begin
				data_reg[data_idx] <= wmerge(data_reg[data_idx], dat_i, sel_i);
			end
		end
	end

	// ----------------------------------------------------------------
	// results and challenge response
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_reg <= card_cmd_pkg::RES_NONE;
			resp_reg <= 64'h0;
			key_spec_reg <= 1'b0;
			key_num_reg <= 5'h00;
		end else if (exec) begin
			result_reg <= result_next;
			if (do_chal) begin
				// [RULE11] [RULE13] [RULE15] [RULE16]
				resp_reg <= old_code ^ CARD_SECRET ^ {8{p2}};
				key_spec_reg <= p2[card_cmd_pkg::P2_SPECIFIC_BIT];
				key_num_reg <= p2[4:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// non-volatile card state
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			files_reg <= '0; // [RULE23]
			unblock_code_reg <= UNBLOCK_CODE_INIT;
			code_reg <= CODE_INIT;
			unblock_ctr_reg <= card_cmd_pkg::UNBLOCK_TRIES_INIT;
			code_ctr_reg <= card_cmd_pkg::CODE_TRIES_INIT;
			code_en_reg <= 1'b1;
		end else begin
			if (do_suspend || do_resume) begin // [RULE5] [RULE8]
				files_reg[fidx] <= do_suspend; // [RULE4] [RULE7]
			end
			if (unb_good) begin
				code_reg <= new_code; // [RULE20]
				unblock_ctr_reg <= card_cmd_pkg::UNBLOCK_TRIES_INIT;
				code_ctr_reg <= card_cmd_pkg::CODE_TRIES_INIT;
				code_en_reg <= 1'b1;
			end else if (unb_bad) begin
				unblock_ctr_reg <= unblock_ctr_reg - 4'h1; // [RULE21]
			end
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = rdata_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_bad_unblock;
		exec && (cmd == card_cmd_pkg::CMD_UNBLOCK) &&
			(!p1_zero || (lc != card_cmd_pkg::UNBLOCK_LC) || le_pres);
	endsequence
	sequence s_rejected;
		##1 (result_reg == card_cmd_pkg::RES_BAD_PARAM);
	endsequence

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		req && !ack_reg |=> ack_o ##1 !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack not a single-cycle answer");

	property p_unblock_frame;
		@(posedge clk_i) disable iff (rst_i || por_i)
		s_bad_unblock |-> s_rejected;
	endproperty
	a_unblock_frame: assert property (p_unblock_frame) // [RULE1]
		else $error("bad unblock framing accepted");

	property p_reject_keeps;
		@(posedge clk_i) disable iff (rst_i || por_i)
		exec && !hdr_ok |=> $stable(files_reg) &&
			$stable(unblock_ctr_reg) && $stable(code_reg);
	endproperty
	a_reject_keeps: assert property (p_reject_keeps) // [RULE22]
		else $error("rejected command changed state");

	property p_suspend_sets;
		@(posedge clk_i) disable iff (rst_i || por_i)
		do_suspend |=> files_reg[$past(fidx)] &&
			(result_reg == card_cmd_pkg::RES_OK);
	endproperty
	a_suspend_sets: assert property (p_suspend_sets) // [RULE4]
		else $error("suspend did not set flag");

	property p_no_ac_no_change;
		@(posedge clk_i) disable iff (rst_i || por_i)
		exec && hdr_ok && ((cmd == card_cmd_pkg::CMD_SUSPEND && !ac_suspend)
			|| (cmd == card_cmd_pkg::CMD_RESUME && !ac_resume))
			|=> $stable(files_reg) && (result_reg == card_cmd_pkg::RES_DENIED);
	endproperty
	a_no_ac_no_change: assert property (p_no_ac_no_change) // [RULE5] [RULE8]
		else $error("file state changed without access condition");

	property p_refuse_off;
		@(posedge clk_i) disable iff (rst_i || por_i)
		exec && (cmd == card_cmd_pkg::CMD_FILE_OP) && file_off
			|=> result_reg == card_cmd_pkg::RES_REFUSED;
	endproperty
	a_refuse_off: assert property (p_refuse_off) // [RULE6]
		else $error("operation on suspended file not refused");

	property p_resume_clears;
		@(posedge clk_i) disable iff (rst_i || por_i)
		do_resume |=> !files_reg[$past(fidx)];
	endproperty
	a_resume_clears: assert property (p_resume_clears) // [RULE7]
		else $error("resume did not clear flag");

	property p_chal_rfu;
		@(posedge clk_i) disable iff (rst_i || por_i)
		exec && (cmd == card_cmd_pkg::CMD_CHALLENGE) && (p2[6:5] != 2'b00)
			|-> s_rejected;
	endproperty
	a_chal_rfu: assert property (p_chal_rfu) // [RULE14]
		else $error("reserved challenge key bits accepted");

	property p_unblock_good;
		@(posedge clk_i) disable iff (rst_i || por_i)
		unb_good |=> (unblock_ctr_reg == card_cmd_pkg::UNBLOCK_TRIES_INIT)
			&& (code_ctr_reg == card_cmd_pkg::CODE_TRIES_INIT) &&
			code_en_reg && (code_reg == $past(new_code));
	endproperty
	a_unblock_good: assert property (p_unblock_good) // [RULE20]
		else $error("correct unblock did not restore counters");

	property p_unblock_bad;
		@(posedge clk_i) disable iff (rst_i || por_i)
		unb_bad |=> (unblock_ctr_reg == $past(unblock_ctr_reg) - 4'h1) &&
			$stable(code_reg) && $stable(code_en_reg);
	endproperty
	a_unblock_bad: assert property (p_unblock_bad) // [RULE21]
		else $error("wrong unblock did not decrement counter");
endmodule : card_command_decoder

// [dv/terminal_model.sv]
// terminal side model: issues classic wishbone cycles to the card decoder
// assumes one clock; xfer is called right after a rising edge
module terminal_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'hff;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// ----------------------------------------------------------------
	// one transfer, held until ack is sampled high
	// ----------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// released lines must not keep the last value
		adr_o <= ~a;
		dat_o <= ~d;
		sel_o <= 4'h0;
		@(posedge clk_i);
	endtask : xfer
endmodule : terminal_model

// [dv/card_command_decoder_bench.sv]
// self-checking bench of the card command decoder
// assumes terminal_model speaks wishbone; checks via register reads
`define CHK(what, exp, got) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("[FAIL] %s expected %h seen %h", what, exp, got); \
		end \
	end

module card_command_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// arbitrary secrets
	localparam logic [63:0] SECRET = 64'h0f1e_2d3c_4b5a_6978;
	localparam logic [63:0] UNB = 64'h1111_2222_3333_4444;
	localparam logic [63:0] CHAL = 64'ha5a5_0101_7e7e_3c3c;
	localparam card_cmd_pkg::res_t OK = card_cmd_pkg::RES_OK;
	localparam card_cmd_pkg::res_t BAD = card_cmd_pkg::RES_BAD_PARAM;
	localparam card_cmd_pkg::cmd_t CH = card_cmd_pkg::CMD_CHALLENGE;
	localparam card_cmd_pkg::cmd_t UB = card_cmd_pkg::CMD_UNBLOCK;
	localparam logic [7:0] ST = card_cmd_pkg::OFF_STATUS;
	localparam logic [7:0] FL = card_cmd_pkg::OFF_FILES;
	logic clk_i, rst_i, por_i, cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, st;
	logic [7:0] kp [3] = '{8'h01, 8'h1f, 8'h85};
	logic [7:0] bp [3] = '{8'h40, 8'h20, 8'hc1};
	int mismatches, n_compared, cycles;

	card_command_decoder #(.NUM_FILES(16), .UNBLOCK_CODE_INIT(UNB),
		.CARD_SECRET(SECRET)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.por_i(por_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack));
	terminal_model term (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
		.cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(wdat));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		term.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic chk(input string what, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		term.xfer(1'b0, a, 32'h0, q);
		`CHK(what, e, q)
	endtask : chk

	task automatic load(input logic [127:0] p);
		for (int i = 0; i < 4; i++) begin
			wr(card_cmd_pkg::OFF_DATA0 + 8'(4 * i), p[32 * i +: 32]);
		end
	endtask : load

	task automatic run(input card_cmd_pkg::cmd_t k, input logic [31:0] h,
		input logic [31:0] o, input card_cmd_pkg::res_t r);
		wr(card_cmd_pkg::OFF_HDR, h);
		wr(card_cmd_pkg::OFF_OPT, o);
		wr(card_cmd_pkg::OFF_CTRL, {23'h0, 1'b1, 5'h0, k});
		term.xfer(1'b0, ST, 32'h0, st);
		`CHK("result", r, st[2:0])
	endtask : run

	task automatic conclude();
		if (mismatches == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		por_i = 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		@(posedge clk_i);
		chk("status", ST, 32'h0000_13a0);
		chk("files", FL, 32'h0);
		wr(8'h80, 32'hdead_beef);
		chk("unmapped", 8'h80, 32'h0);
		load({64'h9, UNB});
		chk("data2", card_cmd_pkg::OFF_DATA2, 32'h9);
		run(UB, 32'h0010_0101, 0, BAD);
		run(UB, 32'h0008_0100, 0, BAD);
		run(UB, 32'h0010_0100, 1, BAD);
		run(UB, 32'h0010_4100, 0, BAD);
		run(UB, 32'h0010_0000, 0, BAD);
		`CHK("state", 16'h13a2, st[15:0])
		load({64'h9, ~UNB});
		run(UB, 32'h0010_8100, 0, card_cmd_pkg::RES_WRONG_CODE);
		`CHK("tries", 16'h1395, st[15:0])
		load({64'h9, UNB});
		run(UB, 32'h0010_1f00, 0, OK);
		`CHK("tries", 16'h13a1, st[15:0])
		run(card_cmd_pkg::CMD_SUSPEND, 0, 32'h0f00,
			card_cmd_pkg::RES_DENIED);
		chk("files", FL, 32'h0);
		run(card_cmd_pkg::CMD_SUSPEND, 32'h0002_0001, 32'h0f02, BAD);
		run(card_cmd_pkg::CMD_SUSPEND, 32'h0002_0000, 32'h0f03, BAD);
		run(card_cmd_pkg::CMD_SUSPEND, 32'h0002_0008, 32'h0f02, OK);
		chk("files", FL, 32'h0000_8000);
		run(card_cmd_pkg::CMD_FILE_OP, 0, 32'h0f00,
			card_cmd_pkg::RES_REFUSED);
		run(card_cmd_pkg::CMD_FILE_OP, 0, 32'h0e00, OK);
		run(card_cmd_pkg::CMD_SELECT, 32'h0002_0004, 32'h0f00, OK);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("files", FL, 32'h0000_8000);
		chk("hdr", card_cmd_pkg::OFF_HDR, 32'h0);
		run(card_cmd_pkg::CMD_RESUME, 0, 32'h0f00,
			card_cmd_pkg::RES_DENIED);
		chk("files", FL, 32'h0000_8000);
		run(card_cmd_pkg::CMD_RESUME, 0, 32'h0f04, OK);
		chk("files", FL, 32'h0);
		run(card_cmd_pkg::CMD_SELECT, 0, 0, OK);
		load({64'h0, CHAL});
		foreach (kp[i]) begin
			run(CH, {16'h1008, kp[i], 8'h00}, 1, OK);
			`CHK("key", {kp[i][7], kp[i][4:0]}, {st[23], st[20:16]})
		end
		chk("resp0", card_cmd_pkg::OFF_RESP0,
			CHAL[31:0] ^ SECRET[31:0] ^ 32'h8585_8585);
		chk("resp1", card_cmd_pkg::OFF_RESP1,
			CHAL[63:32] ^ SECRET[63:32] ^ 32'h8585_8585);
		run(CH, 32'h1008_0000, 1, OK);
		chk("resp0", card_cmd_pkg::OFF_RESP0,
			CHAL[31:0] ^ SECRET[31:0]);
		foreach (bp[i]) begin
			run(CH, {16'h1008, bp[i], 8'h00}, 1, BAD);
		end
		run(CH, 32'h1008_8501, 1, BAD);
		run(CH, 32'h1000_8500, 1, BAD);
		run(CH, 32'h0008_8500, 0, BAD);
		run(card_cmd_pkg::CMD_PROFILE, 32'h0004_0000, 0, OK);
		run(card_cmd_pkg::CMD_PROFILE, 32'h0004_0001, 0, BAD);
		run(card_cmd_pkg::CMD_PROFILE, 32'h0004_0100, 0, BAD);
		run(card_cmd_pkg::CMD_PROFILE, 32'h0004_0000, 1, BAD);
		run(card_cmd_pkg::CMD_WRAPPED, 32'h2004_0000, 1, OK);
		run(card_cmd_pkg::CMD_WRAPPED, 32'h0004_0000, 0, OK);
		run(card_cmd_pkg::CMD_WRAPPED, 32'h2004_0100, 1, BAD);
		chk("kind", card_cmd_pkg::OFF_CTRL, 32'h5);
		chk("opt", card_cmd_pkg::OFF_OPT, 32'h1);
		load({64'h9, ~UNB});
		for (int i = 9; i >= 0; i--) begin
			run(UB, 32'h0010_0100, 0, card_cmd_pkg::RES_WRONG_CODE);
			`CHK("tries", 4'(i), st[7:4])
		end
		`CHK("code tries", 4'h3, st[11:8])
		load({64'h9, UNB});
		run(UB, 32'h0010_0100, 0, card_cmd_pkg::RES_BLOCKED);
		conclude();
	end
endmodule : card_command_decoder_bench
